// ===== rtl/cwd_pkg.sv
package cwd_pkg;
	// Ratios are kept as log2 so that shifts stand in for multipliers.
	localparam logic [2:0] CWD_PRE_LOG2_HI = 3'h7;
	localparam logic [2:0] CWD_PRE_LOG2_LO = 3'h5;
	localparam logic [3:0] CWD_POST_LOG2_OFS = 4'h0;
	localparam int CWD_PERIOD_W = 32;
	localparam int CWD_BASE_W = 8;
	localparam int CWD_PCT_W = 10;
	// Window share in tenths of a percent.
	localparam logic [9:0] CWD_WIN_PCT_11 = 10'h0FA;
	localparam logic [9:0] CWD_WIN_PCT_10 = 10'h177;
	localparam logic [9:0] CWD_WIN_PCT_01 = 10'h1F4;
	localparam logic [9:0] CWD_WIN_PCT_00 = 10'h2EE;
	localparam logic [1:0] CWD_ICS_PAIR1 = 2'h3;
	localparam logic [1:0] CWD_ICS_PAIR2 = 2'h2;
	localparam logic [1:0] CWD_ICS_PAIR3 = 2'h1;
	localparam logic [1:0] CWD_ICS_RSVD = 2'h0;
	localparam logic [2:0] CWD_PAIR_NONE = 3'h0;
	localparam logic [2:0] CWD_PAIR1_ONEHOT = 3'h1;
	localparam logic [2:0] CWD_PAIR2_ONEHOT = 3'h2;
	localparam logic [2:0] CWD_PAIR3_ONEHOT = 3'h4;
	localparam logic CWD_ERASED_BIT = 1'b1;
	localparam int CWD_FUSE_W = 10;
	typedef enum logic [1:0] {
		CWD_ST_RESET = 2'b00,
		CWD_ST_LOAD  = 2'b01,
		CWD_ST_RUN   = 2'b10
	} cwd_state_t;
endpackage

// ===== rtl/cwd_i2c_route.sv
`timescale 1ns/1ns
module cwd_i2c_route
	import cwd_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Selection
	input  wire logic load,
	input  wire logic alt_sel,
	// Routing
	output logic      primary_en,
	output logic      alternate_en
);
	wire use_primary = alt_sel;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			primary_en   <= 1'b0;
			alternate_en <= 1'b0;
		end else if (load) begin
			primary_en   <= use_primary;
			alternate_en <= ~use_primary;
		end
	end
endmodule

// ===== rtl/cwd_decoder.sv
`timescale 1ns/1ns
// Summary of operation
// - Prescale bit 1 selects 1:128, bit 0 selects 1:32.
// - Postscale code 1111 is 1:32768, 1110 is 1:16384, lower codes halve.
// - Window codes 11,10,01,00 give 25, 37.5, 50, 75 percent of period.
// - Port 1 uses primary pins when its select is 1, else alternate pins.
// - Port 2 uses primary pins when its select is 1, else alternate pins.
// - Debug port enable 1 enables the test port; 0 keeps it disabled.
// - Channel codes 11,10,01 select debug pairs one, two, three.
// - An erased device reads debug port enable as 1.
module cwd_decoder
	import cwd_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	// Raw configuration fields
	input  wire logic                    fuse_valid,
	input  wire logic                    fuse_erased,
	input  wire logic                    wdog_prescale_select,
	input  wire logic [3:0]              wdog_postscale_field,
	input  wire logic [1:0]              wdog_window_select,
	input  wire logic                    i2c_port1_alt_pin_select,
	input  wire logic                    i2c_port2_alt_pin_select,
	input  wire logic                    debug_port_enable,
	input  wire logic [1:0]              debug_channel_select,
	input  wire logic [CWD_BASE_W-1:0]   wdog_base_period,
	// Watchdog settings
	output logic [3:0]                   wdog_prescale_log2,
	output logic [3:0]                   wdog_postscale_log2,
	output logic [CWD_PCT_W-1:0]         wdog_window_permille,
	output logic [CWD_PERIOD_W-1:0]      wdog_timeout_period,
	// Pin routing
	output logic                         port1_primary_en,
	output logic                         port1_alternate_en,
	output logic                         port2_primary_en,
	output logic                         port2_alternate_en,
	output logic                         jtag_enable,
	output logic [2:0]                   debug_pair_onehot,
	output logic                         debug_channel_reserved,
	output logic                         config_ready
);
	cwd_state_t state_r;
	cwd_state_t state_nxt;

	function automatic logic [2:0] cwd_pair_decode(input logic [1:0] code);
		case (code)
			CWD_ICS_PAIR1: cwd_pair_decode = CWD_PAIR1_ONEHOT;
			CWD_ICS_PAIR2: cwd_pair_decode = CWD_PAIR2_ONEHOT;
			CWD_ICS_PAIR3: cwd_pair_decode = CWD_PAIR3_ONEHOT;
			default:       cwd_pair_decode = CWD_PAIR_NONE;
		endcase
	endfunction

	// An erased array reads every field except wdog_base_period as all ones.
	wire       eff_pre  = fuse_erased ? CWD_ERASED_BIT : wdog_prescale_select;
	wire [3:0] eff_post = fuse_erased ? {4{CWD_ERASED_BIT}} : wdog_postscale_field;
	wire [1:0] eff_win  = fuse_erased ? {2{CWD_ERASED_BIT}} : wdog_window_select;
	wire       eff_alt1 = fuse_erased ? CWD_ERASED_BIT : i2c_port1_alt_pin_select;
	wire       eff_alt2 = fuse_erased ? CWD_ERASED_BIT : i2c_port2_alt_pin_select;
	wire       eff_jtag = fuse_erased ? CWD_ERASED_BIT : debug_port_enable;
	wire [1:0] eff_ics  = fuse_erased ? {2{CWD_ERASED_BIT}} : debug_channel_select;

	wire [3:0] pre_log2_w  = eff_pre ? {1'b0, CWD_PRE_LOG2_HI}
		: {1'b0, CWD_PRE_LOG2_LO};
	wire [3:0] post_log2_w = eff_post + CWD_POST_LOG2_OFS;
	wire [CWD_PCT_W-1:0] win_w = (eff_win == 2'h3) ? CWD_WIN_PCT_11
		: (eff_win == 2'h2) ? CWD_WIN_PCT_10
		: (eff_win == 2'h1) ? CWD_WIN_PCT_01 : CWD_WIN_PCT_00;
	wire [4:0] shift_w = 5'(pre_log2_w) + 5'(post_log2_w);
	wire [CWD_PERIOD_W-1:0] period_w =
		CWD_PERIOD_W'(wdog_base_period) << shift_w;
	wire [2:0] pair_w = cwd_pair_decode(eff_ics);
	wire       load_w = (state_r == CWD_ST_LOAD);

	always_comb begin
		case (state_r)
			CWD_ST_RESET: state_nxt = CWD_ST_LOAD;
			CWD_ST_LOAD:  state_nxt = fuse_valid ? CWD_ST_RUN : CWD_ST_LOAD;
			CWD_ST_RUN:   state_nxt = CWD_ST_RUN;
			default:      state_nxt = CWD_ST_RESET;
		endcase
	end

	// Fields are captured once after reset; later changes on the inputs are ignored.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_r <= CWD_ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wdog_prescale_log2     <= 4'h0;
			wdog_postscale_log2    <= 4'h0;
			wdog_window_permille   <= '0;
			wdog_timeout_period    <= '0;
			jtag_enable            <= 1'b0;
			debug_pair_onehot      <= CWD_PAIR_NONE;
			debug_channel_reserved <= 1'b0;
			config_ready           <= 1'b0;
		end else if (load_w && fuse_valid) begin
			wdog_prescale_log2     <= pre_log2_w;
			wdog_postscale_log2    <= post_log2_w;
			wdog_window_permille   <= win_w;
			wdog_timeout_period    <= period_w;
			jtag_enable            <= eff_jtag;
			debug_pair_onehot      <= pair_w;
			debug_channel_reserved <= (eff_ics == CWD_ICS_RSVD);
			config_ready           <= 1'b1;
		end
	end

	cwd_i2c_route u_port1 (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.load         (load_w && fuse_valid),
		.alt_sel      (eff_alt1),
		.primary_en   (port1_primary_en),
		.alternate_en (port1_alternate_en)
	);

	cwd_i2c_route u_port2 (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.load         (load_w && fuse_valid),
		.alt_sel      (eff_alt2),
		.primary_en   (port2_primary_en),
		.alternate_en (port2_alternate_en)
	);

	wire cap_w = load_w && fuse_valid;

	property p_pre;
		@(posedge clk_sys) disable iff (reset)
		cap_w |=> wdog_prescale_log2 == ($past(eff_pre) ? 4'h7 : 4'h5);
	endproperty
	a_pre: assert property (p_pre) else $error("prescale wrong");

	property p_post;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_post == 4'hF |=> wdog_postscale_log2 == 4'hF;
	endproperty
	a_post: assert property (p_post) else $error("postscale wrong");

	property p_win;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_win == 2'h2 |=> wdog_window_permille == 10'h177;
	endproperty
	a_win: assert property (p_win) else $error("window wrong");

	property p_p1;
		@(posedge clk_sys) disable iff (reset)
		cap_w |=> port1_primary_en == $past(eff_alt1) && port1_alternate_en != port1_primary_en;
	endproperty
	a_p1: assert property (p_p1) else $error("port1 route wrong");

	property p_p2;
		@(posedge clk_sys) disable iff (reset)
		cap_w |=> port2_primary_en == $past(eff_alt2) && port2_alternate_en != port2_primary_en;
	endproperty
	a_p2: assert property (p_p2) else $error("port2 route wrong");

	property p_jtag;
		@(posedge clk_sys) disable iff (reset)
		cap_w |=> jtag_enable == $past(eff_jtag);
	endproperty
	a_jtag: assert property (p_jtag) else $error("jtag enable wrong");

	property p_pair;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_ics == 2'h3 |=> debug_pair_onehot == 3'h1;
	endproperty
	a_pair: assert property (p_pair) else $error("debug pair wrong");

	property p_erased;
		@(posedge clk_sys) disable iff (reset)
		cap_w && fuse_erased |=> jtag_enable;
	endproperty
	a_erased: assert property (p_erased) else $error("erased jtag not on");

	property p_period;
		@(posedge clk_sys) disable iff (reset)
		cap_w |=> wdog_timeout_period ==
			(CWD_PERIOD_W'($past(wdog_base_period))
			<< (5'(wdog_prescale_log2) + 5'(wdog_postscale_log2)));
	endproperty
	a_period: assert property (p_period) else $error("period wrong");

	property p_post_e;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_post == 4'hE |=> wdog_postscale_log2 == 4'hE;
	endproperty
	a_post_e: assert property (p_post_e) else $error("postscale code 14 wrong");

	property p_win_25;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_win == 2'h3 |=> wdog_window_permille == 10'h0FA;
	endproperty
	a_win_25: assert property (p_win_25) else $error("window 25 wrong");

	property p_win_75;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_win == 2'h0 |=> wdog_window_permille == 10'h2EE;
	endproperty
	a_win_75: assert property (p_win_75) else $error("window 75 wrong");

	property p_pair2;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_ics == 2'h2 |=> debug_pair_onehot == 3'h2;
	endproperty
	a_pair2: assert property (p_pair2) else $error("debug pair two wrong");

	property p_pair3;
		@(posedge clk_sys) disable iff (reset)
		cap_w && eff_ics == 2'h1 |=> debug_pair_onehot == 3'h4;
	endproperty
	a_pair3: assert property (p_pair3) else $error("debug pair three wrong");

	property p_jtag_off;
		@(posedge clk_sys) disable iff (reset)
		cap_w && !fuse_erased && !debug_port_enable |=> !jtag_enable;
	endproperty
	a_jtag_off: assert property (p_jtag_off) else $error("jtag not kept off");
endmodule

// ===== test/cwd_decoder_bench.sv
`timescale 1ns/1ns
module cwd_decoder_bench
	import cwd_pkg::*;
();
	logic                  clk_sys = 1'b0;
	logic                  reset, fuse_valid, fuse_erased, wdog_prescale_select;
	logic [3:0]            wdog_postscale_field;
	logic [1:0]            wdog_window_select, debug_channel_select;
	logic                  i2c_port1_alt_pin_select, i2c_port2_alt_pin_select, debug_port_enable;
	logic [CWD_BASE_W-1:0] wdog_base_period;
	logic [3:0]            wdog_prescale_log2, wdog_postscale_log2;
	logic [CWD_PCT_W-1:0]  wdog_window_permille;
	logic [31:0]           wdog_timeout_period;
	logic                  port1_primary_en, port1_alternate_en, port2_primary_en;
	logic                  port2_alternate_en, jtag_enable, debug_channel_reserved, config_ready;
	logic [2:0]            debug_pair_onehot;
	int                    errors = 0;
	int                    n_tests = 0;

	always #4 clk_sys = ~clk_sys;

	cwd_decoder dut_u (.clk_sys, .reset, .fuse_valid, .fuse_erased, .wdog_prescale_select,
		.wdog_postscale_field, .wdog_window_select, .i2c_port1_alt_pin_select,
		.i2c_port2_alt_pin_select, .debug_port_enable, .debug_channel_select, .wdog_base_period,
		.wdog_prescale_log2, .wdog_postscale_log2, .wdog_window_permille, .wdog_timeout_period,
		.port1_primary_en, .port1_alternate_en, .port2_primary_en, .port2_alternate_en,
		.jtag_enable, .debug_pair_onehot, .debug_channel_reserved, .config_ready);

	task automatic wrap_up();
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	// Expectations come from the field values, with an erased array reading as all ones.
	task automatic run_cfg(input logic er, pre, input logic [3:0] post, input logic [1:0] win,
		input logic a1, a2, jt, input logic [1:0] ics, input logic [7:0] base);
		logic [3:0]  e_pre;
		logic [3:0]  e_post;
		logic [1:0]  e_ics;
		logic [9:0]  e_win;
		int          n;
		e_pre = (er | pre) ? {1'b0, CWD_PRE_LOG2_HI} : {1'b0, CWD_PRE_LOG2_LO};
		e_post = er ? 4'hF : post;
		e_ics = er ? 2'h3 : ics;
		e_win = er ? CWD_WIN_PCT_11 : win == 2'h3 ? CWD_WIN_PCT_11 : win == 2'h2 ?
			CWD_WIN_PCT_10 : win == 2'h1 ? CWD_WIN_PCT_01 : CWD_WIN_PCT_00;
		@(posedge clk_sys);
		reset <= 1'b1;
		fuse_valid <= 1'b0;
		fuse_erased <= er;
		wdog_prescale_select <= pre;
		wdog_postscale_field <= post;
		wdog_window_select <= win;
		i2c_port1_alt_pin_select <= a1;
		i2c_port2_alt_pin_select <= a2;
		debug_port_enable <= jt;
		debug_channel_select <= ics;
		wdog_base_period <= base;
		@(posedge clk_sys);
		reset <= 1'b0;
		// Two edges pass with the fields not yet valid, so nothing may be taken.
		repeat (3) @(negedge clk_sys);
		cmp("config_ready", 32'h0, {31'h0, config_ready});
		cmp("jtag_idle", 32'h0, {31'h0, jtag_enable});
		@(posedge clk_sys);
		fuse_valid <= 1'b1;
		n = 0;
		while (config_ready !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		if (config_ready !== 1'b1) begin
			errors++;
			wrap_up();
		end
		// Inputs moved after capture must not disturb the settings.
		@(posedge clk_sys);
		{wdog_prescale_select, wdog_postscale_field, i2c_port1_alt_pin_select} <= ~{pre, post, a1};
		{debug_port_enable, debug_channel_select, fuse_erased} <= ~{jt, ics, er};
		repeat (2) @(negedge clk_sys);
		cmp("prescale", {28'h0, e_pre}, {28'h0, wdog_prescale_log2});
		cmp("postscale", {28'h0, e_post}, {28'h0, wdog_postscale_log2});
		cmp("window", {22'h0, e_win}, {22'h0, wdog_window_permille});
		cmp("port1", {30'h0, er | a1, ~(er | a1)}, {30'h0, port1_primary_en, port1_alternate_en});
		cmp("port2", {30'h0, er | a2, ~(er | a2)}, {30'h0, port2_primary_en, port2_alternate_en});
		cmp("jtag", {31'h0, er | jt}, {31'h0, jtag_enable});
		cmp("pair", {29'h0, e_ics == 2'h3 ? CWD_PAIR1_ONEHOT : e_ics == 2'h2 ? CWD_PAIR2_ONEHOT :
			e_ics == 2'h1 ? CWD_PAIR3_ONEHOT : CWD_PAIR_NONE}, {29'h0, debug_pair_onehot});
		cmp("reserved", {31'h0, e_ics == 2'h0}, {31'h0, debug_channel_reserved});
		cmp("timeout", {24'h0, base} << (int'(e_pre) + int'(e_post)), wdog_timeout_period);
	endtask

	task automatic sc_pair1();
		run_cfg(1'b0, 1'b1, 4'hF, 2'h3, 1'b1, 1'b0, 1'b0, 2'h3, 8'hFF);
	endtask

	task automatic sc_pair2();
		run_cfg(1'b0, 1'b0, 4'hE, 2'h2, 1'b0, 1'b1, 1'b1, 2'h2, 8'h03);
	endtask

	task automatic sc_pair3();
		run_cfg(1'b0, 1'b1, 4'h0, 2'h1, 1'b1, 1'b1, 1'b0, 2'h1, 8'h81);
	endtask

	// The reserved code is applied to see that no pair is chosen and the reserved flag is set, with all other settings checked too.
	task automatic sc_reserved();
		run_cfg(1'b0, 1'b0, 4'h7, 2'h0, 1'b0, 1'b0, 1'b1, 2'h0, 8'h5A);
	endtask

	task automatic sc_erased();
		run_cfg(1'b1, 1'b0, 4'h0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 8'h02);
	endtask

	task automatic sc_post_codes();
		for (int c = 0; c < 16; c++)
			run_cfg(1'b0, c[0], c[3:0], c[1:0], c[1], c[2], c[3], 2'h3, 8'h01);
	endtask

	initial begin
		{reset, fuse_valid, fuse_erased, wdog_prescale_select, wdog_postscale_field} <= 8'h80;
		{wdog_window_select, i2c_port1_alt_pin_select, i2c_port2_alt_pin_select} <= 4'h0;
		{debug_port_enable, debug_channel_select, wdog_base_period} <= 11'h000;
		repeat (4) @(posedge clk_sys);
		sc_pair1();
		sc_pair2();
		sc_pair3();
		sc_reserved();
		sc_erased();
		sc_post_codes();
		wrap_up();
	end
endmodule
